/* design/gism_pkg.sv */
// Constants, types and decode helpers for the GPIO input source and threshold block
package gism_pkg;

   // ==========================================================================
   // Register map
   localparam logic [31:0] GISM_BANK_THRESHOLD_CTRL_ADDR = 32'hE004_2078;
   localparam logic [31:0] GISM_INPUT_SOURCE_SELECT_ADDR = 32'hE004_207C;
   localparam logic [31:0] GISM_PAD_SIDE_SELECT_ADDR = 32'hE004_2080;

   // ==========================================================================
   // Field layout and reset values
   localparam int GISM_EAST_LSB = 0;
   localparam int GISM_WEST_LSB = 2;
   localparam int GISM_THR_W = 2;
   localparam int GISM_SEL_W = 16;
   localparam logic [3:0] GISM_BANK_THRESHOLD_RESET = 4'h0;
   localparam logic [15:0] GISM_INPUT_SOURCE_RESET = 16'h0000;
   localparam logic [15:0] GISM_PAD_SIDE_RESET = 16'h0000;

   // ==========================================================================
   // Line numbering
   localparam int GISM_LINE_BASE = 16;
   localparam int GISM_SECONDARY_BASE = 41;
   localparam int GISM_NUM_LINES = 16;
   // Multiplexer 1 side A is input only: output and enable held low
   localparam logic [15:0] GISM_PERIPH_INPUT_ONLY = 16'h0002;

   // ==========================================================================
   // Bus encodings
   localparam logic [1:0] GISM_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] GISM_HTRANS_SEQ = 2'h3;
   localparam logic GISM_HRESP_OKAY = 1'h0;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      GISM_STD_3V3 = 2'h0,
      GISM_STD_2V5 = 2'h1,
      GISM_STD_1V8 = 2'h2,
      GISM_STD_1V5 = 2'h3
   } gism_level_t;

   typedef struct packed {
      gism_level_t in_level;
      gism_level_t out_level;
   } gism_bank_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
   } gism_drive_t;

   // Code 11 splits: 1.5 V input with 1.8 V output
   function automatic gism_bank_cfg_t gism_decode_threshold(input logic [1:0] code);
      gism_bank_cfg_t cfg;
      cfg.in_level = GISM_STD_3V3;
      cfg.out_level = GISM_STD_3V3;
      case (code)
         2'h1: begin
            cfg.in_level = GISM_STD_2V5;
            cfg.out_level = GISM_STD_2V5;
         end
         2'h2: begin
            cfg.in_level = GISM_STD_1V8;
            cfg.out_level = GISM_STD_1V8;
         end
         2'h3: begin
            cfg.in_level = GISM_STD_1V5;
            cfg.out_level = GISM_STD_1V8;
         end
         default: begin
            cfg.in_level = GISM_STD_3V3;
            cfg.out_level = GISM_STD_3V3;
         end
      endcase
      return cfg;
   endfunction : gism_decode_threshold

endpackage : gism_pkg

/* design/gism_pad_mux.sv */
// One pad multiplexer cell: two alternative sides steered onto one pad
`timescale 1ns/1ps
module gism_pad_mux
   import gism_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic sel,
   input wire gism_drive_t a_drive,
   input wire gism_drive_t b_drive,
   input wire logic pad_in,
   output gism_drive_t pad_drive,
   output logic a_in,
   output logic b_in
);

   // ==========================================================================
   // Pad input synchroniser
   logic sync1_reg;
   logic sync2_reg;

   always_ff @(posedge clk) begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
   end

   // ==========================================================================
   // Side steering
   wire gism_drive_t drive_next = sel ? b_drive : a_drive;
   wire logic a_in_next = ~sel & sync2_reg;
   wire logic b_in_next = sel & sync2_reg;

   // Unselected side reads zero so it never sees a foreign signal
   always_ff @(posedge clk) begin
      if (reset) begin
         pad_drive <= '0;
         a_in <= 1'b0;
         b_in <= 1'b0;
      end else begin
         pad_drive <= drive_next;
         a_in <= a_in_next;
         b_in <= b_in_next;
      end
   end

endmodule : gism_pad_mux

/* design/gism_top.sv */
// Bank threshold control and input source selection for GPIO lines 16 to 31
//
// Operation
// - Threshold register: west bank field bits 3:2, east bits 1:0, reset zero.
// - Field codes: 00 3.3V, 01 2.5V, 10 1.8V, 11 1.5V in, 1.8V out.
// - Sixteen source bits; bit n picks line 16+n from mux n or 41+n.
// - Set source bit lets the processor read the fabric signal on that line.
// - Pad muxes route peripheral, GPIO or fabric with separate in, out, enable.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module gism_top
   import gism_pkg::*;
#(
   parameter int NUM_LINES = GISM_NUM_LINES
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NUM_LINES-1:0] pad_in,
   output gism_drive_t [NUM_LINES-1:0] pad_drive,
   input wire gism_drive_t [NUM_LINES-1:0] periph_drive,
   output logic [NUM_LINES-1:0] periph_in,
   input wire gism_drive_t [NUM_LINES-1:0] line_drive,
   output logic [NUM_LINES-1:0] line_input,
   input wire logic [NUM_LINES-1:0] fabric_to_subsystem,
   output gism_drive_t [NUM_LINES-1:0] subsystem_to_fabric,
   output gism_bank_cfg_t east_bank_cfg,
   output gism_bank_cfg_t west_bank_cfg
);

   // ==========================================================================
   // Elaboration check
   // Select registers are 16 bits wide, so no more lines can be served
   if (NUM_LINES < 1 || NUM_LINES > GISM_SEL_W) begin : g_bad_lines
      $error("NUM_LINES must lie between 1 and 16");
   end

   // ==========================================================================
   // Bus slave: address phase capture
   logic [31:0] addr_reg;
   logic write_reg;
   logic active_reg;
   logic [3:0] bank_threshold_ctrl_reg;
   logic [15:0] input_source_select_reg;
   logic [15:0] pad_side_select_reg;

   wire logic addr_phase = hsel & hready & htrans[1];
   wire logic wr_phase = active_reg & write_reg;
   wire logic hit_bank = addr_reg == GISM_BANK_THRESHOLD_CTRL_ADDR;
   wire logic hit_src = addr_reg == GISM_INPUT_SOURCE_SELECT_ADDR;
   wire logic hit_side = addr_reg == GISM_PAD_SIDE_SELECT_ADDR;

   always_ff @(posedge clk) begin
      if (reset) begin
         addr_reg <= '0;
         write_reg <= 1'b0;
         active_reg <= 1'b0;
      end else begin
         active_reg <= addr_phase;
         if (addr_phase) begin
            addr_reg <= haddr;
            write_reg <= hwrite;
         end
      end
   end

   // ==========================================================================
   // Register writes in the data phase
   wire logic [3:0] bank_threshold_ctrl_next = (wr_phase && hit_bank) ? hwdata[3:0] : bank_threshold_ctrl_reg;
   wire logic [15:0] input_source_select_next = (wr_phase && hit_src) ? hwdata[15:0] : input_source_select_reg;
   wire logic [15:0] pad_side_select_next = (wr_phase && hit_side) ? hwdata[15:0] : pad_side_select_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         bank_threshold_ctrl_reg <= GISM_BANK_THRESHOLD_RESET;
         input_source_select_reg <= GISM_INPUT_SOURCE_RESET;
         pad_side_select_reg <= GISM_PAD_SIDE_RESET;
      end else begin
         bank_threshold_ctrl_reg <= bank_threshold_ctrl_next;
         input_source_select_reg <= input_source_select_next;
         pad_side_select_reg <= pad_side_select_next;
      end
   end

   // ==========================================================================
   // Read data, zero wait states
   // Read mux looks at next values so a read right after a write sees it
   wire logic rd_bank = haddr == GISM_BANK_THRESHOLD_CTRL_ADDR;
   wire logic rd_src = haddr == GISM_INPUT_SOURCE_SELECT_ADDR;
   wire logic rd_side = haddr == GISM_PAD_SIDE_SELECT_ADDR;
   wire logic [31:0] rd_word = rd_bank ? {28'h000_0000, bank_threshold_ctrl_next} :
                               rd_src ? {16'h0000, input_source_select_next} :
                               rd_side ? {16'h0000, pad_side_select_next} : 32'h0000_0000;
   wire logic rd_phase = addr_phase & ~hwrite;

   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= GISM_HRESP_OKAY;
      end else begin
         hrdata <= rd_phase ? rd_word : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= GISM_HRESP_OKAY;
      end
   end

   // ==========================================================================
   // Bank threshold decode
   wire gism_bank_cfg_t east_next = gism_decode_threshold(bank_threshold_ctrl_reg[GISM_EAST_LSB +: GISM_THR_W]);
   wire gism_bank_cfg_t west_next = gism_decode_threshold(bank_threshold_ctrl_reg[GISM_WEST_LSB +: GISM_THR_W]);

   always_ff @(posedge clk) begin
      if (reset) begin
         east_bank_cfg <= '0;
         west_bank_cfg <= '0;
      end else begin
         east_bank_cfg <= east_next;
         west_bank_cfg <= west_next;
      end
   end

   // ==========================================================================
   // Primary and secondary multiplexers per line
   logic [NUM_LINES-1:0] pri_line_in;
   logic [NUM_LINES-1:0] sec_line_in;
   logic [NUM_LINES-1:0] line_input_next;

   for (genvar n = 0; n < NUM_LINES; n++) begin : g_line
      // Input-only peripheral lanes never drive their pad
      wire gism_drive_t periph_a = GISM_PERIPH_INPUT_ONLY[n] ? '0 : periph_drive[n];

      gism_pad_mux u_primary (
         .clk(clk),
         .reset(reset),
         .sel(pad_side_select_reg[n]),
         .a_drive(periph_a),
         .b_drive(line_drive[n]),
         .pad_in(pad_in[n]),
         .pad_drive(pad_drive[n]),
         .a_in(periph_in[n]),
         .b_in(pri_line_in[n])
      );

      // Fabric side sits where the pad would; GPIO output also goes to fabric
      gism_pad_mux u_secondary (
         .clk(clk),
         .reset(reset),
         .sel(1'b1),
         .a_drive('0),
         .b_drive(line_drive[n]),
         .pad_in(fabric_to_subsystem[n]),
         .pad_drive(subsystem_to_fabric[n]),
         .a_in(),
         .b_in(sec_line_in[n])
      );

      assign line_input_next[n] = input_source_select_reg[n] ? sec_line_in[n] : pri_line_in[n];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         line_input <= '0;
      end else begin
         line_input <= line_input_next;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic [3:0] wdata_bank_d;
   always_ff @(posedge clk) begin
      wdata_bank_d <= hwdata[3:0];
   end

   thr_write_a: assert property (wr_phase && hit_bank |=> bank_threshold_ctrl_reg == wdata_bank_d)
      else $error("threshold register missed a write");

   thr_reset_a: assert property ($past(reset) && !reset |-> bank_threshold_ctrl_reg == 4'h0 &&
                                 input_source_select_reg == 16'h0000)
      else $error("registers not zero after reset");

   thr_split_a: assert property (bank_threshold_ctrl_reg == 4'hF |=>
                                 west_bank_cfg.in_level == GISM_STD_1V5 && west_bank_cfg.out_level == GISM_STD_1V8 &&
                                 east_bank_cfg.in_level == GISM_STD_1V5)
      else $error("code 11 decode wrong");

   thr_default_a: assert property (bank_threshold_ctrl_reg == 4'h0 |=>
                                   east_bank_cfg == '0 && west_bank_cfg == '0)
      else $error("default threshold wrong");

   src_fabric_a: assert property ((input_source_select_reg[0] && $stable(fabric_to_subsystem[0]))[*5] |->
                                  line_input[0] == fabric_to_subsystem[0])
      else $error("fabric signal not seen on line input");

   src_primary_a: assert property ((!input_source_select_reg[0] && pad_side_select_reg[0] &&
                                    $stable(pad_in[0]))[*5] |-> line_input[0] == pad_in[0])
      else $error("primary pad not seen on line input");

   pad_route_a: assert property ((pad_side_select_reg[0])[*2] |-> pad_drive[0] == $past(line_drive[0]))
      else $error("pad not driven from line side");

   in_only_a: assert property ((!pad_side_select_reg[1])[*2] |-> pad_drive[1] == '0)
      else $error("input-only side drives pad");

   serial_out_a: assert property ((!pad_side_select_reg[0])[*2] |-> pad_drive[0] == $past(periph_drive[0]))
      else $error("serial output not on pad");

   bus_okay_a: assert property (hreadyout && hresp == GISM_HRESP_OKAY)
      else $error("bus answer not ready okay");

   // Excludes a write landing in the same cycle, which the read mux forwards
   src_read_a: assert property (rd_phase && rd_src && !(wr_phase && hit_src) |=>
                                hrdata[15:0] == input_source_select_reg)
      else $error("source select read back wrong");

   cov_fabric_c: cover property (input_source_select_reg[0] && fabric_to_subsystem[0] ##4 line_input[0]);
   cov_thr_c: cover property (wr_phase && hit_bank ##1 bank_threshold_ctrl_reg == 4'hF);
   cov_read_c: cover property (rd_phase && rd_src ##1 hrdata != 32'h0000_0000);

endmodule : gism_top

/* tb/gism_far_model.sv */
// Pad and fabric user logic seen from the far side of the block
`timescale 1ns/1ps
module gism_far_model
   import gism_pkg::*;
(
   input wire gism_drive_t [15:0] pad_drive,
   input wire logic [15:0] released_level,
   input wire logic [15:0] fabric_level,
   output logic [15:0] pad_in,
   output logic [15:0] fabric_to_subsystem
);
   // ========================================
   // Pads
   // No pull on these pads: a released pad shows a bench level, not the last drive
   always_comb begin
      for (int n = 0; n < 16; n++) begin
         pad_in[n] = pad_drive[n].oe ? pad_drive[n].out : released_level[n];
      end
   end
   // ========================================
   // Fabric
   assign fabric_to_subsystem = fabric_level;
endmodule : gism_far_model

/* tb/gism_top_bench.sv */
// Self-checking bench for the threshold and input source block
`timescale 1ns/1ps
module gism_top_bench
   import gism_pkg::*;
;
   logic clk, reset, hsel, hwrite, samp, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [15:0] pad_in, periph_in, line_input, f2s, pad_ext, fab_val, sel, pin_exp;
   gism_drive_t [15:0] pad_drive, periph_drv, line_drv, s2f;
   gism_bank_cfg_t east_cfg, west_cfg;
   int mismatches, total_checks;
   int sel_q[$];
   logic [31:0] exp_q[$];

   gism_top dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pad_in(pad_in), .pad_drive(pad_drive), .periph_drive(periph_drv),
      .periph_in(periph_in), .line_drive(line_drv), .line_input(line_input), .fabric_to_subsystem(f2s),
      .subsystem_to_fabric(s2f), .east_bank_cfg(east_cfg), .west_bank_cfg(west_cfg));
   gism_far_model far_u (.pad_drive(pad_drive), .released_level(pad_ext), .fabric_level(fab_val),
      .pad_in(pad_in), .fabric_to_subsystem(f2s));

   // ========================================
   // Helpers
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction : rnd
   function automatic logic [3:0] lvl(input logic [1:0] c);
      return {c, (c == 2'h3) ? 2'h2 : c};
   endfunction : lvl
   function automatic logic [31:0] obs(input int s);
      case (s)
         0: return hrdata;
         1: return {24'h0000_00, east_cfg, west_cfg};
         2: return {16'h0000, line_input};
         3: return pad_drive;
         5: return {16'h0000, periph_in};
         default: return s2f;
      endcase
   endfunction : obs
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= GISM_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : {rnd(), rnd()};
      if (!wr) begin
         sel_q.push_back(0);
         exp_q.push_back(e);
         samp <= 1'b1;
      end
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      samp <= 1'b0;
   endtask : bus
   task automatic note(input int s, input logic [31:0] e);
      @(posedge clk);
      sel_q.push_back(s);
      exp_q.push_back(e);
      samp <= 1'b1;
      @(posedge clk);
      samp <= 1'b0;
   endtask : note
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   // ========================================
   // Monitor: oldest note against what the outputs show
   always @(posedge clk) begin
      if (samp === 1'b1 && hreadyout === 1'b1 && sel_q.size() > 0) begin
         total_checks++;
         if (obs(sel_q[0]) !== exp_q[0]) begin
            mismatches++;
            $display("[ERR] %0t kind %0d got %h exp %h", $time, sel_q[0], obs(sel_q[0]), exp_q[0]);
         end
         void'(sel_q.pop_front());
         void'(exp_q.pop_front());
      end
   end

   // ========================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   // ========================================
   // Stimulus
   initial begin
      {reset, hsel, hwrite, samp} = 4'h8;
      {htrans, hsize} = 5'h02;
      {haddr, hwdata} = '0;
      seed = 32'h0001_8402;
      {pad_ext, fab_val, periph_drv, line_drv} = '0;
      mismatches = 0;
      total_checks = 0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      bus(1'b0, GISM_BANK_THRESHOLD_CTRL_ADDR, 0, 0);
      bus(1'b0, GISM_INPUT_SOURCE_SELECT_ADDR, 0, 0);
      note(1, 0);
      // Upper bits set on purpose: they must not stick
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, GISM_BANK_THRESHOLD_CTRL_ADDR, 32'hFFFF_FFF0 | (c << 2) | (3 - c), 0);
         bus(1'b0, GISM_BANK_THRESHOLD_CTRL_ADDR, 0, (c << 2) | (3 - c));
         note(1, {lvl(2'(3 - c)), lvl(2'(c))});
      end
      // Both banks on the split code at once
      bus(1'b1, GISM_BANK_THRESHOLD_CTRL_ADDR, 32'h0000_000F, 0);
      note(1, {lvl(2'h3), lvl(2'h3)});
      bus(1'b1, GISM_PAD_SIDE_SELECT_ADDR + 32'h0000_0004, {rnd(), rnd()}, 0);
      bus(1'b0, GISM_PAD_SIDE_SELECT_ADDR + 32'h0000_0004, 0, 0);
      bus(1'b1, GISM_PAD_SIDE_SELECT_ADDR, 32'h0000_FFFF, 0);
      for (int i = 0; i < 4; i++) begin
         sel = rnd();
         pad_ext <= rnd();
         fab_val <= rnd();
         bus(1'b1, GISM_INPUT_SOURCE_SELECT_ADDR, {rnd(), sel}, 0);
         bus(1'b0, GISM_INPUT_SOURCE_SELECT_ADDR, 0, {16'h0000, sel});
         repeat (8) @(posedge clk);
         note(2, {16'h0000, (sel & fab_val) | (~sel & pad_ext)});
      end
      line_drv <= {rnd(), rnd()};
      repeat (3) @(posedge clk);
      note(3, line_drv);
      note(4, line_drv);
      bus(1'b1, GISM_PAD_SIDE_SELECT_ADDR, 0, 0);
      periph_drv <= {rnd(), rnd()};
      repeat (3) @(posedge clk);
      note(3, periph_drv & 32'hFFFF_FFF3);
      // Side A input sees the pad: own drive where enabled, except input-only line 1, else the released level
      for (int n = 0; n < 16; n++) begin
         pin_exp[n] = (n != 1 && periph_drv[n].oe) ? periph_drv[n].out : pad_ext[n];
      end
      note(5, {16'h0000, pin_exp});
      // Let the monitor take the last note before the run ends
      @(posedge clk);
      print_verdict();
   end
endmodule : gism_top_bench
